// >>> typec_pkg.sv
// Shared types, timing constants and current levels for the Type-C attach block.
// Assumes CC comparator flags and VBUS detect arrive synchronous to core_clk.
// Functional notes
// - Source-only port without a sink pull-down stays unattached, VBUS and VCONN off.
// - Sink-only port without pull-up or VBUS stays unattached as sink.
// - Source sees pull-down, waits, attaches once pull-down held for the debounce time.
// - Entering attached source turns on both VBUS and VCONN.
// - Attached source-only port watches CC; pull-down lost returns to unattached source.
// - Demanding sinks wait on pull-up ignoring VBUS; simple sinks may attach on VBUS.
// - Sink attaches once VBUS detected; losing VBUS returns it to unattached sink.
// - Dual-role port with nothing attached alternates unattached source and sink.
// - Dual-role source sees pull-down, waits debounce, attaches and powers VBUS, VCONN.
// - Dual-role attached source losing pull-down returns unattached and resumes toggling.
// - Dual-role sink sees pull-up, waits, then attaches when VBUS appears.
// - Dual-role sink may optionally try source role before settling as sink.
// - Dual-role attached sink losing VBUS returns unattached and resumes toggling.
// - Power ranking: PD, Type-C 3.0 A, Type-C 1.5 A, battery charging, default.
// - With a PD contract active only the contract current counts.
// - PD ending falls back to Type-C current, then charging, then default.
// - Type-C current detection is always present; other mechanisms are optional.
// - Any state tolerates a source that always supplies VBUS.
`default_nettype none

package typec_pkg;

  // Clock rate and timing figures in microseconds
  localparam int CLK_MHZ         = 40;
  localparam int CC_DEBOUNCE_US  = 150;
  localparam int CC_DEBOUNCE_CYC = CC_DEBOUNCE_US * CLK_MHZ;
  localparam int DRP_TOGGLE_US   = 35;
  localparam int DRP_TOGGLE_CYC  = DRP_TOGGLE_US * CLK_MHZ;
  localparam int TRY_TIMEOUT_US  = 100;
  localparam int TRY_TIMEOUT_CYC = TRY_TIMEOUT_US * CLK_MHZ;

  // Counter widths
  localparam int TIMER_W = 16;
  localparam int DEB_W   = 20;

  // Current limits in mA
  localparam logic [15:0] MA_NONE   = 16'h0000;
  localparam logic [15:0] MA_USB2   = 16'h01f4;
  localparam logic [15:0] MA_USB3   = 16'h0384;
  localparam logic [15:0] MA_BC     = 16'h05dc;
  localparam logic [15:0] MA_TC_1A5 = 16'h05dc;
  localparam logic [15:0] MA_TC_3A0 = 16'h0bb8;

  typedef enum logic [1:0] {
    ROLE_SRC = 2'h0,
    ROLE_SNK = 2'h1,
    ROLE_DRP = 2'h2
  } port_role_t;

  typedef enum logic [1:0] {
    RP_NONE    = 2'h0,
    RP_DEFAULT = 2'h1,
    RP_1A5     = 2'h2,
    RP_3A0     = 2'h3
  } rp_level_t;

  typedef enum logic [7:0] {
    UNATT_SRC   = 8'h01,
    ATTWAIT_SRC = 8'h02,
    ATT_SRC     = 8'h04,
    UNATT_SNK   = 8'h08,
    ATTWAIT_SNK = 8'h10,
    ATT_SNK     = 8'h20,
    TRY_SRC     = 8'h40,
    TRYWAIT_SNK = 8'h80
  } conn_state_t;

  typedef enum logic [2:0] {
    PSRC_NONE    = 3'h0,
    PSRC_DEFAULT = 3'h1,
    PSRC_BC      = 3'h2,
    PSRC_TC_1A5  = 3'h3,
    PSRC_TC_3A0  = 3'h4,
    PSRC_PD      = 3'h5
  } pwr_src_t;

  typedef struct packed {
    logic      rd_seen;
    logic      rp_seen;
    rp_level_t rp_level;
  } cc_sense_t;

  typedef struct packed {
    logic        pd_active;
    logic [15:0] pd_ma;
    logic        bc_active;
    logic        usb3;
  } pwr_req_t;

  typedef struct packed {
    pwr_src_t    src;
    logic [15:0] limit_ma;
  } pwr_sel_t;

  typedef struct packed {
    logic vbus_en;
    logic vconn_en;
    logic pullup_en;
    logic pulldown_en;
  } port_drive_t;

endpackage

`default_nettype wire

// >>> cc_debounce.sv
// Debounce filter for the CC pull-up and pull-down flags.
// Assumes inputs are synchronous; stable means held unchanged for CYC cycles.
`default_nettype none

module cc_debounce #(
  parameter int W   = 2,
  parameter int CYC = typec_pkg::CC_DEBOUNCE_CYC
)(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Raw flags in, filtered flags out
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level,
  output logic              stable
);
  import typec_pkg::*;

  typedef struct packed {
    logic [W-1:0]     last;
    logic [DEB_W-1:0] cnt;
    logic             stable;
  } deb_t;

  deb_t cur_reg;
  deb_t cur_next;

  // Any change restarts the count, so glitches never qualify
  always_comb
  begin
    cur_next = cur_reg;
    if (raw != cur_reg.last)
    begin
      cur_next.last   = raw;
      cur_next.cnt    = '0;
      cur_next.stable = 1'b0;
    end
    else if (cur_reg.cnt != DEB_W'(CYC - 1))
      cur_next.cnt = cur_reg.cnt + 1'b1;
    else
      cur_next.stable = 1'b1;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign level  = cur_reg.last;
  assign stable = cur_reg.stable;

endmodule

`default_nettype wire

// >>> power_select.sv
// Chooses the governing power mechanism and current limit for an attached sink.
// Assumes PD and charging flags come from their own controllers.
`default_nettype none

module power_select (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Attach state, advertised level and mechanism requests
  input  wire logic                 attached_snk,
  input  wire typec_pkg::rp_level_t rp_level,
  input  wire typec_pkg::pwr_req_t  pwr_req,
  // Selection
  output typec_pkg::pwr_sel_t       pwr_sel
);
  import typec_pkg::*;

  pwr_sel_t sel_reg;
  pwr_sel_t sel_next;

  // Strict priority; dropping a higher source falls to the next by itself
  always_comb
  begin
    sel_next = '{src: PSRC_NONE, limit_ma: MA_NONE};
    if (attached_snk)
    begin
      if (pwr_req.pd_active)
        sel_next = '{src: PSRC_PD, limit_ma: pwr_req.pd_ma};
      else if (rp_level == RP_3A0)
        sel_next = '{src: PSRC_TC_3A0, limit_ma: MA_TC_3A0};
      else if (rp_level == RP_1A5)
        sel_next = '{src: PSRC_TC_1A5, limit_ma: MA_TC_1A5};
      else if (pwr_req.bc_active)
        sel_next = '{src: PSRC_BC, limit_ma: MA_BC};
      else
        sel_next = '{src: PSRC_DEFAULT, limit_ma: pwr_req.usb3 ? MA_USB3 : MA_USB2};
    end
  end

  // Selection register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sel_reg <= '{src: PSRC_NONE, limit_ma: MA_NONE};
    else
      sel_reg <= sel_next;
  end

  assign pwr_sel = sel_reg;

endmodule

`default_nettype wire

// >>> typec_attach_power_select.sv
// Connection state logic of a Type-C port: source-only, sink-only or dual-role.
// Assumes CC detect flags and VBUS detect are synchronous to core_clk.
`default_nettype none

module typec_attach_power_select #(
  parameter int DEBOUNCE_CYC = typec_pkg::CC_DEBOUNCE_CYC,
  parameter int TOGGLE_CYC   = typec_pkg::DRP_TOGGLE_CYC,
  parameter int TRY_CYC      = typec_pkg::TRY_TIMEOUT_CYC
)(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // Port configuration
  input  wire typec_pkg::port_role_t role,
  input  wire logic                  sink_needs_wait,
  input  wire logic                  try_src_en,
  // Sensed line conditions
  input  wire typec_pkg::cc_sense_t  cc_in,
  input  wire logic                  vbus_present,
  // Power mechanism requests
  input  wire typec_pkg::pwr_req_t   pwr_req,
  // Port drive and status
  output typec_pkg::port_drive_t     drive,
  output typec_pkg::conn_state_t     conn_state,
  output logic                       attached_src,
  output logic                       attached_snk,
  output typec_pkg::pwr_sel_t        pwr_sel
);
  import typec_pkg::*;

  typedef struct packed {
    conn_state_t        st;
    logic [TIMER_W-1:0] tmr;
    port_drive_t        drv;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{st: UNATT_SRC, tmr: '0, drv: '{1'b0, 1'b0, 1'b1, 1'b0}};

  ctl_t        cur_reg;
  ctl_t        cur_next;
  logic [1:0]  deb_level;
  logic        deb_stable;
  logic        deb_rd;
  logic        deb_rp;
  logic        toggle_hit;
  logic        try_hit;
  logic        src_side;

  //////////////////////////////////////////////////////////////////////////////

  // CC flags filtered together; either changing restarts the wait
  cc_debounce #(
    .W   (2),
    .CYC (DEBOUNCE_CYC)
  ) u_deb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .raw      ({cc_in.rd_seen, cc_in.rp_seen}),
    .level    (deb_level),
    .stable   (deb_stable)
  );

  // Settled CC condition and timer expiry decodes
  assign deb_rd     = deb_stable & deb_level[1];
  assign deb_rp     = deb_stable & deb_level[0];
  assign toggle_hit = (cur_reg.tmr == TIMER_W'(TOGGLE_CYC - 1));
  assign try_hit    = (cur_reg.tmr == TIMER_W'(TRY_CYC - 1));

  //////////////////////////////////////////////////////////////////////////////

  // Next state; the timer restarts on every state change
  always_comb
  begin
    cur_next     = cur_reg;
    cur_next.tmr = cur_reg.tmr + 1'b1;
    case (cur_reg.st)
      UNATT_SRC:
      begin
        if (role == ROLE_SNK)
          cur_next.st = UNATT_SNK;
        else if (cc_in.rd_seen)
          cur_next.st = ATTWAIT_SRC;
        else if (role == ROLE_DRP && toggle_hit)
          cur_next.st = UNATT_SNK;
        else if (role == ROLE_SRC)
          cur_next.tmr = '0;
      end
      ATTWAIT_SRC:
      begin
        // Foreign VBUS still present: never power into it
        if (deb_rd && !vbus_present)
          cur_next.st = ATT_SRC;
        else if (deb_stable && !deb_level[1])
          cur_next.st = UNATT_SRC;
      end
      ATT_SRC:
      begin
        if (deb_stable && !deb_level[1])
          cur_next.st = UNATT_SRC;
      end
      UNATT_SNK:
      begin
        if (role == ROLE_SRC)
          cur_next.st = UNATT_SRC;
        else if (cc_in.rp_seen)
          cur_next.st = ATTWAIT_SNK;
        else if (role == ROLE_SNK && !sink_needs_wait && vbus_present)
          cur_next.st = ATT_SNK;
        else if (role == ROLE_DRP && toggle_hit)
          cur_next.st = UNATT_SRC;
        else if (role == ROLE_SNK)
          cur_next.tmr = '0;
      end
      ATTWAIT_SNK:
      begin
        if (deb_rp && vbus_present)
        begin
          if (role == ROLE_DRP && try_src_en)
            cur_next.st = TRY_SRC;
          else
            cur_next.st = ATT_SNK;
        end
        else if (deb_stable && !deb_level[0])
          cur_next.st = UNATT_SNK;
      end
      ATT_SNK:
      begin
        if (!vbus_present)
          cur_next.st = UNATT_SNK;
      end
      TRY_SRC:
      begin
        if (cc_in.rd_seen)
          cur_next.st = ATTWAIT_SRC;
        else if (try_hit)
          cur_next.st = TRYWAIT_SNK;
      end
      TRYWAIT_SNK:
      begin
        if (deb_rp && vbus_present)
          cur_next.st = ATT_SNK;
        else if (try_hit && !cc_in.rp_seen)
          cur_next.st = UNATT_SNK;
      end
      default:
        cur_next.st = UNATT_SRC;
    endcase
    if (cur_next.st != cur_reg.st)
      cur_next.tmr = '0;
    // Terminations and power follow the state being entered
    src_side = cur_next.st inside {UNATT_SRC, ATTWAIT_SRC, ATT_SRC, TRY_SRC};
    cur_next.drv.pullup_en   = src_side;
    cur_next.drv.pulldown_en = !src_side;
    cur_next.drv.vbus_en     = (cur_next.st == ATT_SRC);
    cur_next.drv.vconn_en    = (cur_next.st == ATT_SRC);
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cur_reg <= CTL_RESET;
    else
      cur_reg <= cur_next;
  end

  //////////////////////////////////////////////////////////////////////////////

  // Power mechanism selection for the sink side
  power_select u_psel (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .attached_snk (cur_reg.st == ATT_SNK),
    .rp_level     (cc_in.rp_level),
    .pwr_req      (pwr_req),
    .pwr_sel      (pwr_sel)
  );

  // Outputs straight from the state register
  assign drive        = cur_reg.drv;
  assign conn_state   = cur_reg.st;
  assign attached_src = (cur_reg.st == ATT_SRC);
  assign attached_snk = (cur_reg.st == ATT_SNK);

endmodule

`default_nettype wire

// >>> typec_attach_asserts.sv
// Port checker for the Type-C attach block.
// Assumes the bind hands on the short debounce figure of the bench.
`default_nettype none

module typec_attach_asserts #(
  parameter int DEBOUNCE_CYC = 8
)(
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  // Block inputs
  input wire typec_pkg::port_role_t  role,
  input wire typec_pkg::cc_sense_t   cc_in,
  input wire logic                   vbus_present,
  input wire typec_pkg::pwr_req_t    pwr_req,
  // Block outputs
  input wire typec_pkg::port_drive_t drive,
  input wire typec_pkg::conn_state_t conn_state,
  input wire logic                   attached_src,
  input wire typec_pkg::pwr_sel_t    pwr_sel
);
  import typec_pkg::*;
  int rd_cnt;
  int lost_cnt;

  // Run lengths; counters since the figures are parameters
  always_ff @(posedge core_clk)
  begin
    rd_cnt   <= (rst_n && cc_in.rd_seen) ? rd_cnt + 1 : 0;
    lost_cnt <= (rst_n && attached_src && !cc_in.rd_seen) ? lost_cnt + 1 : 0;
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_VBUS_ATT: assert property ({drive.vbus_en, drive.vconn_en} == {2{conn_state == ATT_SRC}})
    else $error("supply enables");
  AST_SRC_WAIT: assert property (role != ROLE_SNK && conn_state == UNATT_SRC && cc_in.rd_seen
    |=> conn_state == ATTWAIT_SRC) else $error("no wait");
  AST_SRC_IDLE: assert property (role == ROLE_SRC && conn_state == UNATT_SRC && !cc_in.rd_seen
    |=> conn_state == UNATT_SRC) else $error("src idle");
  AST_SNK_IDLE: assert property (role == ROLE_SNK && conn_state == UNATT_SNK
    && !cc_in.rp_seen && !vbus_present |=> conn_state == UNATT_SNK) else $error("snk idle");
  AST_DEBOUNCE: assert property ($rose(attached_src) |-> rd_cnt >= DEBOUNCE_CYC)
    else $error("early attach");
  AST_DETACH: assert property (attached_src |-> lost_cnt <= DEBOUNCE_CYC + 2)
    else $error("late detach");
  AST_SNK_LOSS: assert property (conn_state == ATT_SNK && !vbus_present |=> conn_state == UNATT_SNK)
    else $error("snk loss");
  AST_PD_ONLY: assert property (conn_state == ATT_SNK && pwr_req.pd_active
    |=> pwr_sel == {PSRC_PD, $past(pwr_req.pd_ma)}) else $error("pd rank");

  // Main scenarios
  cover property ($rose(attached_src));
  cover property ($rose(conn_state == ATT_SNK));
  cover property (conn_state == TRY_SRC);
endmodule

bind typec_attach_power_select typec_attach_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) i_chk (
  .core_clk, .rst_n, .role, .cc_in, .vbus_present, .pwr_req, .drive, .conn_state, .attached_src, .pwr_sel);

`default_nettype wire

// >>> far_end.sv
// Far port model: open, sink, source or charger.
// Assumes the bench picks mode and level between steps.
`default_nettype none

module far_end (
  // Chosen behaviour
  input  wire logic [1:0]             mode,
  input  wire typec_pkg::rp_level_t   lvl,
  // Local terminations
  input  wire typec_pkg::port_drive_t drv,
  // Sensed by the local port
  output typec_pkg::cc_sense_t        cc,
  output logic                        vbus
);
  import typec_pkg::*;
  // A termination is seen only against the opposite one
  assign cc.rd_seen  = mode == 2'h1 && drv.pullup_en;
  assign cc.rp_seen  = mode == 2'h2 && drv.pulldown_en;
  assign cc.rp_level = cc.rp_seen ? lvl : RP_NONE;
  // Source and charger supply VBUS; a charger never stops
  assign vbus        = mode[1];
endmodule

`default_nettype wire

// >>> tb_top.sv
// Scenario bench for the Type-C attach block.
// Assumes short timing parameters keep each scenario brief.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import typec_pkg::*;
  localparam int DEB = 8;
  logic        core_clk;
  logic        rst_n;
  logic        sink_needs_wait;
  logic        try_src_en;
  logic        vbus_present;
  logic        attached_src;
  logic        attached_snk;
  logic [1:0]  mode;
  port_role_t  role;
  rp_level_t   lvl;
  pwr_req_t    pwr_req;
  cc_sense_t   cc_in;
  port_drive_t drive;
  conn_state_t conn_state;
  pwr_sel_t    pwr_sel;
  int          n_fail;
  int          comparisons;
  int          waited;

  // 40 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  typec_attach_power_select #(.DEBOUNCE_CYC(DEB), .TOGGLE_CYC(6), .TRY_CYC(10)) i_dut (
    .core_clk, .rst_n, .role, .sink_needs_wait, .try_src_en, .cc_in, .vbus_present,
    .pwr_req, .drive, .conn_state, .attached_src, .attached_snk, .pwr_sel);
  far_end i_far (.mode, .lvl, .drv(drive), .cc(cc_in), .vbus(vbus_present));

  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d failed %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // All inputs back to idle, ten cycles of reset
  task automatic do_reset(input port_role_t r);
    rst_n = 1'b0;
    role = r;
    mode = 2'h0;
    lvl = RP_DEFAULT;
    pwr_req = '0;
    sink_needs_wait = 1'b1;
    try_src_en = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
  endtask

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_st(input conn_state_t s);
    for (waited = 0; conn_state !== s; waited++)
    begin
      @(negedge core_clk);
      if (waited > 200)
      begin
        `CHK(conn_state, s)
        print_verdict();
      end
    end
  endtask

  task automatic hold_st(input conn_state_t s);
    logic ok;
    ok = 1'b1;
    repeat (3 * DEB)
    begin
      @(negedge core_clk);
      ok &= conn_state === s;
    end
    `CHK(ok, 1'b1)
  endtask

  task automatic chk_pwr(input pwr_src_t s, input logic [15:0] m);
    repeat (3) @(negedge core_clk);
    `CHK(pwr_sel, {s, m})
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_src();
    do_reset(ROLE_SRC);
    hold_st(UNATT_SRC);
    mode = 2'h1;
    wait_st(ATT_SRC);
    `CHK(waited >= DEB, 1'b1)
    `CHK(attached_src, 1'b1)
    `CHK({drive.vbus_en, drive.vconn_en}, 2'h3)
    mode = 2'h0;
    wait_st(UNATT_SRC);
    `CHK(drive.vbus_en, 1'b0)
    $display("src done");
  endtask

  // Charger VBUS alone must not attach a waiting sink
  task automatic t_snk();
    do_reset(ROLE_SNK);
    hold_st(UNATT_SNK);
    mode = 2'h3;
    hold_st(UNATT_SNK);
    sink_needs_wait = 1'b0;
    wait_st(ATT_SNK);
    `CHK(waited < 3, 1'b1)
    `CHK(attached_snk, 1'b1)
    mode = 2'h0;
    wait_st(UNATT_SNK);
    `CHK(waited < 3, 1'b1)
    `CHK(attached_snk, 1'b0)
    $display("snk done");
  endtask

  task automatic t_pwr();
    do_reset(ROLE_SNK);
    lvl = RP_3A0;
    mode = 2'h2;
    wait_st(ATT_SNK);
    `CHK(waited >= DEB, 1'b1)
    `CHK(attached_snk, 1'b1)
    chk_pwr(PSRC_TC_3A0, MA_TC_3A0);
    lvl = RP_1A5;
    chk_pwr(PSRC_TC_1A5, MA_TC_1A5);
    lvl = RP_DEFAULT;
    pwr_req.usb3 = 1'b1;
    chk_pwr(PSRC_DEFAULT, MA_USB3);
    pwr_req.bc_active = 1'b1;
    chk_pwr(PSRC_BC, MA_BC);
    lvl = RP_3A0;
    pwr_req.pd_ma = 16'h0c80;
    pwr_req.pd_active = 1'b1;
    chk_pwr(PSRC_PD, 16'h0c80);
    pwr_req.pd_active = 1'b0;
    chk_pwr(PSRC_TC_3A0, MA_TC_3A0);
    lvl = RP_DEFAULT;
    chk_pwr(PSRC_BC, MA_BC);
    pwr_req = '0;
    chk_pwr(PSRC_DEFAULT, MA_USB2);
    $display("pwr done");
  endtask

  task automatic t_drp();
    do_reset(ROLE_DRP);
    wait_st(UNATT_SNK);
    `CHK(drive.pulldown_en, 1'b1)
    wait_st(UNATT_SRC);
    mode = 2'h2;
    wait_st(ATTWAIT_SNK);
    wait_st(ATT_SNK);
    mode = 2'h0;
    wait_st(UNATT_SNK);
    `CHK(waited < 3, 1'b1)
    wait_st(UNATT_SRC);
    mode = 2'h1;
    wait_st(ATT_SRC);
    `CHK(waited >= DEB, 1'b1)
    `CHK(attached_src, 1'b1)
    `CHK(drive.vconn_en, 1'b1)
    mode = 2'h0;
    wait_st(UNATT_SRC);
    wait_st(UNATT_SNK);
    $display("drp done");
  endtask

  task automatic t_try();
    do_reset(ROLE_DRP);
    try_src_en = 1'b1;
    mode = 2'h2;
    wait_st(TRY_SRC);
    `CHK(drive.pullup_en, 1'b1)
    wait_st(TRYWAIT_SNK);
    wait_st(ATT_SNK);
    $display("try done");
  endtask

  // Main sequence
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    t_src();
    t_snk();
    t_pwr();
    t_drp();
    t_try();
    print_verdict();
  end
endmodule

`default_nettype wire
